// ---- include/pead_pkg.sv ----
package pead_pkg;

    // register byte offsets
    localparam logic [7:0] PEAD_CTRL_OFS = 8'h00;
    localparam logic [7:0] PEAD_LAMP_OFS = 8'h04;
    localparam logic [7:0] PEAD_TEMP_OFS = 8'h08;
    localparam logic [7:0] PEAD_COLR_OFS = 8'h0C;
    localparam logic [7:0] PEAD_RELAY_OFS = 8'h10;
    localparam logic [7:0] PEAD_SEQ_OFS = 8'h14;
    localparam logic [7:0] PEAD_STAT_OFS = 8'h18;

    // reset values
    localparam logic [31:0] PEAD_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PEAD_LAMP_RST = 32'h0000_0000;
    localparam logic [31:0] PEAD_TEMP_RST = 32'h0000_0000;
    localparam logic [31:0] PEAD_COLR_RST = 32'h0000_0000;
    localparam logic [31:0] PEAD_RELAY_RST = 32'h0000_0000;
    localparam logic [31:0] PEAD_SEQ_RST = 32'h0001_0100;

    // lamp register fields
    localparam int PEAD_LAMP_ACT_LSB = 0;
    localparam int PEAD_LAMP_CTYPE_LSB = 4;
    localparam int PEAD_LAMP_LEVEL_LSB = 8;
    localparam int PEAD_LAMP_SCENE_LSB = 16;
    localparam int PEAD_LAMP_MASK_LSB = 24;

    // sequence register fields
    localparam int PEAD_SEQ_SHORT_LSB = 0;
    localparam int PEAD_SEQ_DOUBLE_LSB = 2;
    localparam int PEAD_SEQ_NONSTOP_BIT = 4;
    localparam int PEAD_SEQ_IMMED_BIT = 5;
    localparam int PEAD_SEQ_COUNT_LSB = 8;
    localparam int PEAD_SEQ_LEN_LSB = 16;

    // control and relay register fields
    localparam int PEAD_CTRL_LONG_BIT = 0;
    localparam int PEAD_RELAY_SHORT_LSB = 0;
    localparam int PEAD_RELAY_LONG_LSB = 2;
    localparam int PEAD_RELAY_DOUBLE_LSB = 4;
    localparam int PEAD_RELAY_MASK_LSB = 8;

    typedef enum logic [1:0] {
        PEAD_PUSH_SHORT = 2'b00,
        PEAD_PUSH_LONG = 2'b01,
        PEAD_PUSH_DOUBLE = 2'b10,
        PEAD_PUSH_NONE = 2'b11
    } pead_push_t;

    typedef enum logic [2:0] {
        PEAD_DBL_DISABLE = 3'b000,
        PEAD_DBL_OFF = 3'b001,
        PEAD_DBL_LEVEL = 3'b010,
        PEAD_DBL_SCENE = 3'b011,
        PEAD_DBL_LOCK = 3'b100,
        PEAD_DBL_UNLOCK = 3'b101,
        PEAD_DBL_LEVEL_TC = 3'b110,
        PEAD_DBL_LEVEL_COL = 3'b111
    } pead_dbl_t;

    typedef enum logic [2:0] {
        PEAD_CT_PLAIN = 3'b000,
        PEAD_CT_TEMP = 3'b001,
        PEAD_CT_XY = 3'b010,
        PEAD_CT_RGB = 3'b011,
        PEAD_CT_RGBW = 3'b100
    } pead_ctype_t;

    // relay and sequence selectors share codes
    typedef enum logic [1:0] {
        PEAD_SEL_DISABLE = 2'b00,
        PEAD_SEL_ON = 2'b01,
        PEAD_SEL_OFF = 2'b10,
        PEAD_SEL_TOGGLE = 2'b11
    } pead_sel_t;

    typedef struct packed {
        logic valid;
        logic [3:0] lamps;
        logic [2:0] action;
        logic [7:0] level;
        logic [3:0] scene;
        logic [15:0] temp;
        logic [23:0] colour;
    } pead_lamp_cmd_t;

    typedef struct packed {
        logic valid;
        logic [3:0] lamps;
        logic [7:0] level;
    } pead_motion_t;

endpackage

// ---- rtl/pead_dispatch.sv ----
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - double push with off action switches every associated lamp off
// - go-to-level double push sets lamps to the configured level
// - go-to-scene double push recalls the one configured scene of sixteen
// - lock action sets per-lamp lock; locked lamps ignore motion commands
// - unlock action clears the lamp lock; motion commands pass again
// - temperature lamps: level-and-temperature applies brightness and temperature
// - xy, rgb, rgbw lamps: level-and-colour applies brightness and colour
// - relay short push: disabled, on, off or toggle
// - relay long push: disabled, on, off or toggle
// - relay double push: disabled, on, off or toggle
// - toggle inverts the relay on each qualifying push
// - sequence short push: disabled, start, stop or toggle
// - sequence toggle starts when idle, stops when running
// - sequence double push: disabled, start, stop or toggle
// - non-stop cycle setting repeats until a stop arrives
// - counted cycles run exactly 1 to 255 loops then end
// - stop-immediately reaction aborts the current step at once
// - complete-the-cycle reaction finishes the pass then halts
// - a disabled push type has no effect on its target
// - long pushes act only while long-press reporting is enabled
module pead_dispatch
    import pead_pkg::*;
#(
    parameter int N_LAMP = 4,
    parameter int N_RELAY = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic push_valid,
    input wire pead_push_t push_type,
    input wire logic seq_step_tick,
    input wire pead_motion_t motion_in,
    output pead_lamp_cmd_t lamp_cmd,
    output pead_motion_t motion_out,
    output logic [N_RELAY-1:0] relay_on,
    output logic seq_running,
    output logic [7:0] seq_step,
    output logic [7:0] seq_loops
);

    ////////////////////////////////////////////////////////////////
    // bus slave

    logic [31:0] ctrl_q;
    logic [31:0] lamp_q;
    logic [31:0] temp_q;
    logic [31:0] colr_q;
    logic [31:0] relay_q;
    logic [31:0] seq_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [N_LAMP-1:0] lock_q;
    logic addr_ok;
    logic [31:0] rd_d;

    assign addr_ok = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= PEAD_CTRL_RST;
            lamp_q <= PEAD_LAMP_RST;
            temp_q <= PEAD_TEMP_RST;
            colr_q <= PEAD_COLR_RST;
            relay_q <= PEAD_RELAY_RST;
            seq_q <= PEAD_SEQ_RST;
        end else if (wr_pend_q) begin
            unique case (wr_addr_q)
                PEAD_CTRL_OFS: begin
                    ctrl_q <= {31'h0000_0000, hwdata[0]};
                end
                PEAD_LAMP_OFS: begin
                    lamp_q <= hwdata;
                end
                PEAD_TEMP_OFS: begin
                    temp_q <= {16'h0000, hwdata[15:0]};
                end
                PEAD_COLR_OFS: begin
                    colr_q <= {8'h00, hwdata[23:0]};
                end
                PEAD_RELAY_OFS: begin
                    relay_q <= hwdata;
                end
                PEAD_SEQ_OFS: begin
                    seq_q <= hwdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        unique case (haddr[7:0])
            PEAD_CTRL_OFS: begin
                rd_d = ctrl_q;
            end
            PEAD_LAMP_OFS: begin
                rd_d = lamp_q;
            end
            PEAD_TEMP_OFS: begin
                rd_d = temp_q;
            end
            PEAD_COLR_OFS: begin
                rd_d = colr_q;
            end
            PEAD_RELAY_OFS: begin
                rd_d = relay_q;
            end
            PEAD_SEQ_OFS: begin
                rd_d = seq_q;
            end
            PEAD_STAT_OFS: begin
                rd_d[3:0] = 4'(relay_on);
                rd_d[7:4] = 4'(lock_q);
                rd_d[8] = seq_running;
                rd_d[23:16] = seq_loops;
                rd_d[31:24] = seq_step;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // push qualification

    logic ev_short;
    logic ev_long;
    logic ev_double;

    assign ev_short = push_valid && push_type == PEAD_PUSH_SHORT;
    assign ev_long = push_valid && push_type == PEAD_PUSH_LONG
        && ctrl_q[PEAD_CTRL_LONG_BIT];
    assign ev_double = push_valid && push_type == PEAD_PUSH_DOUBLE;

    ////////////////////////////////////////////////////////////////
    // lamp double push

    pead_dbl_t dbl_act;
    pead_ctype_t ctype;
    logic [N_LAMP-1:0] lamp_mask;
    logic dbl_ok;

    assign dbl_act = pead_dbl_t'(lamp_q[PEAD_LAMP_ACT_LSB+:3]);
    assign ctype = pead_ctype_t'(lamp_q[PEAD_LAMP_CTYPE_LSB+:3]);
    assign lamp_mask = N_LAMP'(lamp_q[PEAD_LAMP_MASK_LSB+:8]);

    always_comb begin
        dbl_ok = 1'b1;
        unique case (dbl_act)
            PEAD_DBL_DISABLE: begin
                dbl_ok = 1'b0;
            end
            PEAD_DBL_LEVEL_TC: begin
                dbl_ok = ctype == PEAD_CT_TEMP;
            end
            PEAD_DBL_LEVEL_COL: begin
                dbl_ok = ctype == PEAD_CT_XY
                    || ctype == PEAD_CT_RGB
                    || ctype == PEAD_CT_RGBW;
            end
            default: begin
                dbl_ok = 1'b1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lamp_cmd <= '0;
        end else begin
            lamp_cmd.valid <= ev_double && dbl_ok
                && dbl_act != PEAD_DBL_LOCK
                && dbl_act != PEAD_DBL_UNLOCK;
            lamp_cmd.lamps <= 4'(lamp_mask);
            lamp_cmd.action <= dbl_act;
            lamp_cmd.level <= lamp_q[PEAD_LAMP_LEVEL_LSB+:8];
            lamp_cmd.scene <= lamp_q[PEAD_LAMP_SCENE_LSB+:4];
            lamp_cmd.temp <= temp_q[15:0];
            lamp_cmd.colour <= colr_q[23:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // motion lock

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= '0;
        end else if (ev_double && dbl_act == PEAD_DBL_LOCK) begin
            lock_q <= lock_q | lamp_mask;
        end else if (ev_double && dbl_act == PEAD_DBL_UNLOCK) begin
            lock_q <= lock_q & ~lamp_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motion_out <= '0;
        end else begin
            motion_out.lamps <= motion_in.lamps & ~4'(lock_q);
            motion_out.level <= motion_in.level;
            motion_out.valid <= motion_in.valid
                && |(motion_in.lamps & ~4'(lock_q));
        end
    end

    ////////////////////////////////////////////////////////////////
    // relays

    pead_sel_t rel_sel;
    logic [N_RELAY-1:0] rel_mask;

    assign rel_mask = N_RELAY'(relay_q[PEAD_RELAY_MASK_LSB+:4]);

    always_comb begin
        rel_sel = PEAD_SEL_DISABLE;
        if (ev_short) begin
            rel_sel = pead_sel_t'(relay_q[PEAD_RELAY_SHORT_LSB+:2]);
        end else if (ev_long) begin
            rel_sel = pead_sel_t'(relay_q[PEAD_RELAY_LONG_LSB+:2]);
        end else if (ev_double) begin
            rel_sel = pead_sel_t'(relay_q[PEAD_RELAY_DOUBLE_LSB+:2]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_on <= '0;
        end else begin
            unique case (rel_sel)
                PEAD_SEL_DISABLE: begin
                    relay_on <= relay_on;
                end
                PEAD_SEL_ON: begin
                    relay_on <= relay_on | rel_mask;
                end
                PEAD_SEL_OFF: begin
                    relay_on <= relay_on & ~rel_mask;
                end
                PEAD_SEL_TOGGLE: begin
                    relay_on <= relay_on ^ rel_mask;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // sequence

    typedef enum logic [1:0] {
        PEAD_SQ_IDLE = 2'b00,
        PEAD_SQ_RUN = 2'b01,
        PEAD_SQ_DRAIN = 2'b10
    } pead_sq_t;

    pead_sq_t sq_q;
    pead_sq_t sq_d;
    pead_sel_t seq_sel;
    logic seq_start;
    logic seq_stop;
    logic pass_end;
    logic loops_done;
    logic [7:0] seq_len;
    logic [7:0] seq_count;

    assign seq_len = seq_q[PEAD_SEQ_LEN_LSB+:8];
    assign seq_count = seq_q[PEAD_SEQ_COUNT_LSB+:8];

    always_comb begin
        seq_sel = PEAD_SEL_DISABLE;
        if (ev_short) begin
            seq_sel = pead_sel_t'(seq_q[PEAD_SEQ_SHORT_LSB+:2]);
        end else if (ev_double) begin
            seq_sel = pead_sel_t'(seq_q[PEAD_SEQ_DOUBLE_LSB+:2]);
        end
    end

    always_comb begin
        seq_start = 1'b0;
        seq_stop = 1'b0;
        unique case (seq_sel)
            PEAD_SEL_DISABLE: begin
                seq_start = 1'b0;
            end
            PEAD_SEL_ON: begin
                seq_start = 1'b1;
            end
            PEAD_SEL_OFF: begin
                seq_stop = 1'b1;
            end
            PEAD_SEL_TOGGLE: begin
                seq_start = sq_q == PEAD_SQ_IDLE;
                seq_stop = sq_q != PEAD_SQ_IDLE;
            end
        endcase
    end

    assign pass_end = seq_step_tick
        && (seq_step + 8'h01 >= seq_len);
    assign loops_done = !seq_q[PEAD_SEQ_NONSTOP_BIT]
        && (seq_loops + 8'h01 >= seq_count);

    always_comb begin
        sq_d = sq_q;
        unique case (sq_q)
            PEAD_SQ_IDLE: begin
                if (seq_start) begin
                    sq_d = PEAD_SQ_RUN;
                end
            end
            PEAD_SQ_RUN: begin
                if (seq_stop && seq_q[PEAD_SEQ_IMMED_BIT]) begin
                    sq_d = PEAD_SQ_IDLE;
                end else if (pass_end && loops_done) begin
                    sq_d = PEAD_SQ_IDLE;
                end else if (seq_stop) begin
                    sq_d = PEAD_SQ_DRAIN;
                end
            end
            PEAD_SQ_DRAIN: begin
                if (seq_stop && seq_q[PEAD_SEQ_IMMED_BIT]) begin
                    sq_d = PEAD_SQ_IDLE;
                end else if (pass_end) begin
                    sq_d = PEAD_SQ_IDLE;
                end
            end
            default: begin
                sq_d = PEAD_SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sq_q <= PEAD_SQ_IDLE;
        end else begin
            sq_q <= sq_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_step <= 8'h00;
            seq_loops <= 8'h00;
        end else if (sq_d == PEAD_SQ_IDLE) begin
            seq_step <= 8'h00;
            seq_loops <= 8'h00;
        end else if (sq_q == PEAD_SQ_IDLE) begin
            seq_step <= 8'h00;
            seq_loops <= 8'h00;
        end else if (pass_end) begin
            seq_step <= 8'h00;
            seq_loops <= seq_loops + 8'h01;
        end else if (seq_step_tick) begin
            seq_step <= seq_step + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_running <= 1'b0;
        end else begin
            seq_running <= sq_d != PEAD_SQ_IDLE;
        end
    end

endmodule // pead_dispatch

// ---- test/pead_dispatch_asserts.sv ----
`timescale 1ns/1ns
module pead_dispatch_asserts
    import pead_pkg::*;
#(
    parameter int N_RELAY = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic push_valid,
    input wire pead_push_t push_type,
    input wire logic seq_step_tick,
    input wire pead_motion_t motion_in,
    input wire pead_lamp_cmd_t lamp_cmd,
    input wire pead_motion_t motion_out,
    input wire logic [N_RELAY-1:0] relay_on,
    input wire logic seq_running,
    input wire logic [7:0] seq_step,
    input wire logic [7:0] seq_loops
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    // cycle without a double push, then the next one
    sequence s_no_dbl;
        !(push_valid && push_type == PEAD_PUSH_DOUBLE) ##1 1'b1;
    endsequence
    sequence s_no_push;
        !push_valid ##1 1'b1;
    endsequence
    sequence s_no_event;
        !push_valid && !seq_step_tick ##1 1'b1;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_ready;
        $past(hresetn) |-> hreadyout && !hresp;
    endproperty
    property p_cmd_src;
        s_no_dbl |-> !lamp_cmd.valid;
    endproperty
    property p_motion;
        motion_out.valid |-> $past(motion_in.valid)
            && (motion_out.lamps & ~$past(motion_in.lamps)) == 4'h0;
    endproperty
    property p_motion_drop;
        !motion_in.valid |=> !motion_out.valid;
    endproperty
    property p_relay;
        s_no_push |-> $stable(relay_on);
    endproperty
    property p_long_seq;
        push_valid && push_type == PEAD_PUSH_LONG && !seq_running
            && !seq_step_tick |=> !seq_running;
    endproperty
    property p_run_hold;
        s_no_event |-> $stable(seq_running);
    endproperty
    property p_step;
        s_no_event |-> $stable(seq_step) && $stable(seq_loops);
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_ready: assert property (p_ready)
        else $error("bus not ready or bad response");
    a_cmd_src: assert property (p_cmd_src)
        else $error("lamp command without double push");
    a_motion: assert property (p_motion)
        else $error("motion passed to a lamp not commanded");
    a_motion_drop: assert property (p_motion_drop)
        else $error("motion output without motion input");
    a_relay: assert property (p_relay)
        else $error("relay changed without push");
    a_long_seq: assert property (p_long_seq)
        else $error("long push started sequence");
    a_run_hold: assert property (p_run_hold)
        else $error("sequence run state changed on its own");
    a_step: assert property (p_step)
        else $error("sequence step moved without tick");
endmodule // pead_dispatch_asserts

bind pead_dispatch pead_dispatch_asserts #(.N_RELAY(N_RELAY))
    pead_dispatch_asserts_inst (.hclk, .hresetn, .hreadyout, .hresp,
    .push_valid, .push_type, .seq_step_tick, .motion_in, .lamp_cmd,
    .motion_out, .relay_on, .seq_running, .seq_step, .seq_loops);

// ---- test/pead_button_model.sv ----
`timescale 1ns/1ns
module pead_button_model
    import pead_pkg::*;
(
    input wire logic hclk,
    input wire pead_lamp_cmd_t lamp_cmd,
    output logic push_valid,
    output pead_push_t push_type,
    output logic seq_step_tick,
    output pead_motion_t motion_in,
    output int n_cmd
);
    initial begin
        push_valid = 1'b0;
        push_type = PEAD_PUSH_NONE;
        seq_step_tick = 1'b0;
        motion_in = 13'h0000;
        n_cmd = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // lamp side: count command pulses
    always @(posedge hclk) begin
        if (lamp_cmd.valid === 1'b1) n_cmd <= n_cmd + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    // one classified push, one cycle wide
    task automatic push(input pead_push_t t);
        @(posedge hclk);
        push_valid <= 1'b1;
        push_type <= t;
        @(posedge hclk);
        push_valid <= 1'b0;
        push_type <= PEAD_PUSH_NONE;
    endtask
    task automatic tick();
        @(posedge hclk);
        seq_step_tick <= 1'b1;
        @(posedge hclk);
        seq_step_tick <= 1'b0;
    endtask
    // idle motion bus shows inverted lamps
    task automatic motion(input logic [3:0] l);
        @(posedge hclk);
        motion_in <= {1'b1, l, 8'h40};
        @(posedge hclk);
        motion_in <= {1'b0, ~l, 8'hBF};
    endtask
endmodule // pead_button_model

// ---- test/pead_dispatch_bench.sv ----
`timescale 1ns/1ns
module pead_dispatch_bench
    import pead_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic push_valid, seq_step_tick, seq_running;
    pead_push_t push_type;
    pead_motion_t motion_in, motion_out;
    pead_lamp_cmd_t lamp_cmd;
    logic [3:0] relay_on;
    logic [7:0] seq_step, seq_loops;
    int n_cmd, n_mismatch = 0, comparisons = 0, cycles = 0;
    // ct, act, expect command
    logic [6:0] tbl [10] = '{7'h03, 7'h05, 7'h07, 7'h1D, 7'h0C,
        7'h2F, 7'h3F, 7'h4F, 7'h1E, 7'h00};
    pead_dispatch #(.N_LAMP(4), .N_RELAY(4)) pead_dispatch_inst (.hclk,
        .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .push_valid,
        .push_type, .seq_step_tick, .motion_in, .lamp_cmd, .motion_out,
        .relay_on, .seq_running, .seq_step, .seq_loops);
    pead_button_model pead_button_model_inst (.hclk, .lamp_cmd,
        .push_valid, .push_type, .seq_step_tick, .motion_in, .n_cmd);
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles > 5000) begin
            n_mismatch = n_mismatch + 1;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task print_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // single word transfer, one idle cycle after
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic lamp_case(input logic [2:0] ct, input logic [2:0] act,
        input logic ev);
        logic [31:0] r;
        bus(1'b1, PEAD_LAMP_OFS,
            {8'h05, 8'h06, 8'h80, 1'b0, ct, 1'b0, act}, r);
        pead_button_model_inst.push(PEAD_PUSH_DOUBLE);
        #1;
        chk(lamp_cmd.valid, ev);
        if (ev) chk(lamp_cmd.action, act);
        if (ev) chk(lamp_cmd.lamps, 4'h5);
        if (act == PEAD_DBL_LEVEL) chk(lamp_cmd.level, 8'h80);
        if (act == PEAD_DBL_SCENE) chk(lamp_cmd.scene, 4'h6);
        if (act == PEAD_DBL_LEVEL_TC && ev) chk(lamp_cmd.temp, 16'h1234);
        if (act == PEAD_DBL_LEVEL_COL && ev) chk(lamp_cmd.colour, 24'hA5C30F);
    endtask
    task automatic rpush(input pead_push_t t, input logic [3:0] e);
        pead_button_model_inst.push(t);
        #1;
        chk(relay_on, e);
    endtask
    task automatic lock(input pead_dbl_t act, input logic [3:0] e);
        bus(1'b1, PEAD_LAMP_OFS, {8'h05, 21'h000000, act}, rd);
        pead_button_model_inst.push(PEAD_PUSH_DOUBLE);
        #1;
        chk(lamp_cmd.valid, 1'b0);
        pead_button_model_inst.motion(4'hF);
        #1;
        chk(motion_out.lamps, e);
        chk(motion_out.level, 8'h40);
        pead_button_model_inst.motion(4'h5);
        #1;
        chk(motion_out.valid, e[0]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, PEAD_SEQ_OFS, 32'h0, rd);
        chk(rd, PEAD_SEQ_RST);
        bus(1'b0, PEAD_CTRL_OFS, 32'h0, rd);
        chk(rd, PEAD_CTRL_RST);
        bus(1'b0, 8'h1C, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        bus(1'b1, PEAD_TEMP_OFS, 32'h0000_1234, rd);
        bus(1'b1, PEAD_COLR_OFS, 32'h00A5_C30F, rd);
        bus(1'b0, PEAD_TEMP_OFS, 32'h0, rd);
        chk(rd, 32'h0000_1234);
        for (int i = 0; i < 10; i++) lamp_case(tbl[i][6:4], tbl[i][3:1], tbl[i][0]);
        lock(PEAD_DBL_LOCK, 4'hA);
        bus(1'b0, PEAD_STAT_OFS, 32'h0, rd);
        chk(rd[7:4], 4'h5);
        lock(PEAD_DBL_UNLOCK, 4'hF);
        // relays: short on, long off, double toggle
        bus(1'b1, PEAD_RELAY_OFS, 32'h0000_0339, rd);
        rpush(PEAD_PUSH_LONG, 4'h0);
        rpush(PEAD_PUSH_SHORT, 4'h3);
        bus(1'b1, PEAD_CTRL_OFS, 32'h0000_0001, rd);
        rpush(PEAD_PUSH_LONG, 4'h0);
        rpush(PEAD_PUSH_DOUBLE, 4'h3);
        rpush(PEAD_PUSH_DOUBLE, 4'h0);
        bus(1'b1, PEAD_RELAY_OFS, 32'h0000_0330, rd);
        rpush(PEAD_PUSH_DOUBLE, 4'h3);
        rpush(PEAD_PUSH_SHORT, 4'h3);
        // counted sequence: 2 passes of 3 steps
        bus(1'b1, PEAD_SEQ_OFS, 32'h0003_0201, rd);
        pead_button_model_inst.push(PEAD_PUSH_SHORT);
        #1;
        chk(seq_running, 1'b1);
        repeat (5) pead_button_model_inst.tick();
        #1;
        chk(seq_running, 1'b1);
        chk(seq_loops, 8'h01);
        chk(seq_step, 8'h02);
        pead_button_model_inst.tick();
        @(posedge hclk);
        #1;
        chk(seq_running, 1'b0);
        // non-stop, toggle start, double stop completing the pass
        bus(1'b1, PEAD_SEQ_OFS, 32'h0002_001B, rd);
        pead_button_model_inst.push(PEAD_PUSH_SHORT);
        repeat (9) pead_button_model_inst.tick();
        #1;
        chk(seq_running, 1'b1);
        pead_button_model_inst.push(PEAD_PUSH_DOUBLE);
        #1;
        chk(seq_running, 1'b1);
        pead_button_model_inst.tick();
        @(posedge hclk);
        #1;
        chk(seq_running, 1'b0);
        // toggles on both pushes, stop at once
        bus(1'b1, PEAD_SEQ_OFS, 32'h0002_003F, rd);
        pead_button_model_inst.push(PEAD_PUSH_DOUBLE);
        #1;
        chk(seq_running, 1'b1);
        pead_button_model_inst.tick();
        pead_button_model_inst.push(PEAD_PUSH_SHORT);
        #1;
        chk(seq_running, 1'b0);
        chk(n_cmd, 7);
        print_verdict();
    end
endmodule // pead_dispatch_bench
